// file: verilog/mbsp_pkg.sv
package mbsp_pkg;

  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned PCT_FULL = 100;

  localparam logic [11:0] OFF_SUBMODE = 12'h000;
  localparam logic [11:0] OFF_DOUT = 12'h004;
  localparam logic [11:0] OFF_T_STOP = 12'h008;
  localparam logic [11:0] OFF_T_ENGAGE = 12'h00c;
  localparam logic [11:0] OFF_T_RELEASE = 12'h010;
  localparam logic [11:0] OFF_T_SETTLE = 12'h014;
  localparam logic [11:0] OFF_PWM_FREQ = 12'h018;
  localparam logic [11:0] OFF_PWM_DUTY = 12'h01c;
  localparam logic [11:0] OFF_STATUS = 12'h020;

  localparam int unsigned AUTO_BIT = 2;
  localparam int unsigned BRAKE_BIT = 0;
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_BRAKE_BIT = 4;
  localparam int unsigned ST_CURRENT_BIT = 5;
  localparam int unsigned ST_MOTION_BIT = 6;

  localparam logic [15:0] FREQ_MIN = 16'h0001;
  localparam logic [15:0] FREQ_MAX = 16'h07d0;
  localparam logic [7:0] DUTY_MIN = 8'h01;
  localparam logic [7:0] DUTY_MAX = 8'h64;

  localparam logic [31:0] SUBMODE_RST = 32'h0000_0004;
  localparam logic [31:0] DOUT_RST = 32'h0000_0000;
  localparam logic [15:0] DELAY_RST = 16'h0064;
  localparam logic [15:0] FREQ_RST = 16'h03e8;
  localparam logic [7:0] DUTY_RST = 8'h64;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_RELEASE = 3'b001,
    ST_SETTLE = 3'b011,
    ST_RUN = 3'b010,
    ST_STOP = 3'b110,
    ST_HOLD = 3'b111,
    ST_ENGAGE = 3'b101
  } mbsp_state_t;

endpackage

// file: verilog/mbsp_pwm_if.sv
`timescale 1ns/10ps
interface mbsp_pwm_if;
  logic en;
  logic [15:0] freq;
  logic [7:0] duty;
  logic wave;
  modport ctrl (output en, output freq, output duty, input wave);
  modport gen (input en, input freq, input duty, output wave);
endinterface

// file: verilog/mbsp_pwm.sv
`timescale 1ns/10ps
module mbsp_pwm (
  input wire logic pclk,
  input wire logic presetn,
  mbsp_pwm_if.gen pwm
);

  logic [25:0] cnt;
  logic [25:0] per;
  logic [25:0] high;
  logic wave;
  logic [25:0] next_cnt;
  logic [25:0] next_per;
  logic [25:0] next_high;
  logic next_wave;
  logic [25:0] calc_per;
  logic [25:0] calc_high;
  logic [32:0] prod;

  // Frequency and duty are validated at write time, so freq is never zero
  always_comb
  begin
    calc_per = 26'(mbsp_pkg::CLK_HZ / 32'(pwm.freq));
    prod = 33'(calc_per) * 33'(pwm.duty);
    calc_high = 26'(prod / 33'(mbsp_pkg::PCT_FULL));
  end

  always_comb
  begin
    next_cnt = cnt;
    next_per = per;
    next_high = high;
    next_wave = 1'b0;
    if (!pwm.en)
    begin
      // Parked on the last count so the first enabled cycle opens a period
      next_cnt = calc_per - 26'd1;
      next_per = calc_per;
      next_high = calc_high;
      next_wave = 1'b0;
    end
    else if (cnt >= per - 26'd1)
    begin
      // New settings take effect only at a period boundary to avoid runt pulses
      next_cnt = '0;
      next_per = calc_per;
      next_high = calc_high;
      next_wave = (calc_high != '0);
    end
    else
    begin
      next_cnt = cnt + 26'd1;
      next_wave = ((cnt + 26'd1) < high);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= '0;
      per <= 26'd1;
      high <= '0;
      wave <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      per <= next_per;
      high <= next_high;
      wave <= next_wave;
    end
  end

  assign pwm.wave = wave;

endmodule

// file: verilog/mbsp_top.sv
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/10ps
// Notes on behaviour
// - In automatic mode brake stays closed except around Operation enabled.
// - Submode bit 2 set selects automatic brake control.
// - Submode bit 2 clear: brake follows digital output word bit 0.
// - Enable: current on, wait release delay, release brake, wait settle, run.
// - Disable: stop motor, wait delay, engage brake, wait delay, current off.
// - Energised brake output is a PWM waveform; it is a steady level only at duty 100.
// - PWM frequency in hertz; settings above 2000 are rejected.
// - PWM duty is a whole percentage from 1 to 100.
// - Duty 100 holds the brake output permanently on.
module mbsp_top #(
  parameter int unsigned MS_CYCLES = mbsp_pkg::CLK_HZ / mbsp_pkg::MS_PER_S
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic op_enable_req,
  input wire logic motor_standstill,
  output logic motor_current_on,
  output logic motor_stop_req,
  output logic motion_enable,
  output logic brake_out
);

  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

  logic [31:0] drive_submode_select;
  logic [31:0] digital_output_word;
  logic [15:0] t_stop;
  logic [15:0] t_engage;
  logic [15:0] t_release;
  logic [15:0] t_settle;
  logic [15:0] pwm_freq;
  logic [7:0] pwm_duty;
  logic [31:0] next_submode;
  logic [31:0] next_dout;
  logic [15:0] next_t_stop;
  logic [15:0] next_t_engage;
  logic [15:0] next_t_release;
  logic [15:0] next_t_settle;
  logic [15:0] next_pwm_freq;
  logic [7:0] next_pwm_duty;

  logic access;
  logic wr;
  logic mapped;
  logic bad_value;

  mbsp_pkg::mbsp_state_t state;
  mbsp_pkg::mbsp_state_t next_state;
  logic next_current_on;
  logic next_stop_req;
  logic next_motion_enable;
  logic load;
  logic [15:0] load_val;

  logic [15:0] ms_pre;
  logic [15:0] dly;
  logic [15:0] next_ms_pre;
  logic [15:0] next_dly;
  logic ms_tick;
  logic expired;

  logic auto_mode;
  logic seq_release;
  logic brake_release;

  mbsp_pwm_if pwm_bus ();

  // Register bus: zero wait states, errors for unmapped or out-of-range writes
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign pready = access;

  always_comb
  begin
    mapped = 1'b1;
    bad_value = 1'b0;
    case (paddr)
      mbsp_pkg::OFF_SUBMODE, mbsp_pkg::OFF_DOUT, mbsp_pkg::OFF_T_STOP,
      mbsp_pkg::OFF_T_ENGAGE, mbsp_pkg::OFF_T_RELEASE, mbsp_pkg::OFF_T_SETTLE,
      mbsp_pkg::OFF_STATUS:
        mapped = 1'b1;
      mbsp_pkg::OFF_PWM_FREQ:
        bad_value = pwrite && (pwdata > 32'(mbsp_pkg::FREQ_MAX) ||
                    pwdata < 32'(mbsp_pkg::FREQ_MIN));
      mbsp_pkg::OFF_PWM_DUTY:
        bad_value = pwrite && (pwdata > 32'(mbsp_pkg::DUTY_MAX) ||
                    pwdata < 32'(mbsp_pkg::DUTY_MIN));
      default:
        mapped = 1'b0;
    endcase
  end

  assign pslverr = access && (!mapped || bad_value);

  always_comb
  begin
    prdata = '0;
    if (access && !pwrite)
    begin
      case (paddr)
        mbsp_pkg::OFF_SUBMODE: prdata = drive_submode_select;
        mbsp_pkg::OFF_DOUT: prdata = digital_output_word;
        mbsp_pkg::OFF_T_STOP: prdata = {16'h0000, t_stop};
        mbsp_pkg::OFF_T_ENGAGE: prdata = {16'h0000, t_engage};
        mbsp_pkg::OFF_T_RELEASE: prdata = {16'h0000, t_release};
        mbsp_pkg::OFF_T_SETTLE: prdata = {16'h0000, t_settle};
        mbsp_pkg::OFF_PWM_FREQ: prdata = {16'h0000, pwm_freq};
        mbsp_pkg::OFF_PWM_DUTY: prdata = {24'h00_0000, pwm_duty};
        mbsp_pkg::OFF_STATUS:
        begin
          prdata[mbsp_pkg::ST_STATE_LSB +: 3] = state;
          prdata[mbsp_pkg::ST_BRAKE_BIT] = brake_release;
          prdata[mbsp_pkg::ST_CURRENT_BIT] = motor_current_on;
          prdata[mbsp_pkg::ST_MOTION_BIT] = motion_enable;
        end
        default: prdata = '0;
      endcase
    end
  end

  always_comb
  begin
    next_submode = drive_submode_select;
    next_dout = digital_output_word;
    next_t_stop = t_stop;
    next_t_engage = t_engage;
    next_t_release = t_release;
    next_t_settle = t_settle;
    next_pwm_freq = pwm_freq;
    next_pwm_duty = pwm_duty;
    if (wr && !bad_value)
    begin
      case (paddr)
        mbsp_pkg::OFF_SUBMODE: next_submode = pwdata;
        mbsp_pkg::OFF_DOUT: next_dout = pwdata;
        mbsp_pkg::OFF_T_STOP: next_t_stop = pwdata[15:0];
        mbsp_pkg::OFF_T_ENGAGE: next_t_engage = pwdata[15:0];
        mbsp_pkg::OFF_T_RELEASE: next_t_release = pwdata[15:0];
        mbsp_pkg::OFF_T_SETTLE: next_t_settle = pwdata[15:0];
        mbsp_pkg::OFF_PWM_FREQ: next_pwm_freq = pwdata[15:0];
        mbsp_pkg::OFF_PWM_DUTY: next_pwm_duty = pwdata[7:0];
        default: next_submode = drive_submode_select;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      drive_submode_select <= mbsp_pkg::SUBMODE_RST;
      digital_output_word <= mbsp_pkg::DOUT_RST;
      t_stop <= mbsp_pkg::DELAY_RST;
      t_engage <= mbsp_pkg::DELAY_RST;
      t_release <= mbsp_pkg::DELAY_RST;
      t_settle <= mbsp_pkg::DELAY_RST;
      pwm_freq <= mbsp_pkg::FREQ_RST;
      pwm_duty <= mbsp_pkg::DUTY_RST;
    end
    else
    begin
      drive_submode_select <= next_submode;
      digital_output_word <= next_dout;
      t_stop <= next_t_stop;
      t_engage <= next_t_engage;
      t_release <= next_t_release;
      t_settle <= next_t_settle;
      pwm_freq <= next_pwm_freq;
      pwm_duty <= next_pwm_duty;
    end
  end

  // Millisecond delay timer; the prescaler restarts on load so a delay is never short
  assign ms_tick = (ms_pre == MS_LAST);
  assign expired = (dly == 16'h0000);

  always_comb
  begin
    next_ms_pre = ms_tick ? 16'h0000 : ms_pre + 16'h0001;
    next_dly = dly;
    if (load)
    begin
      next_ms_pre = 16'h0000;
      next_dly = load_val;
    end
    else if (ms_tick && !expired)
    begin
      next_dly = dly - 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ms_pre <= '0;
      dly <= '0;
    end
    else
    begin
      ms_pre <= next_ms_pre;
      dly <= next_dly;
    end
  end

  // Power sequencer
  always_comb
  begin
    next_state = state;
    load = 1'b0;
    load_val = 16'h0000;
    case (state)
      mbsp_pkg::ST_OFF:
        if (op_enable_req)
        begin
          next_state = mbsp_pkg::ST_RELEASE;
          load = 1'b1;
          load_val = t_release;
        end
      mbsp_pkg::ST_RELEASE:
        // Brake never opened yet, so an abort can drop current at once
        if (!op_enable_req)
          next_state = mbsp_pkg::ST_OFF;
        else if (expired)
        begin
          next_state = mbsp_pkg::ST_SETTLE;
          load = 1'b1;
          load_val = t_settle;
        end
      mbsp_pkg::ST_SETTLE:
        if (!op_enable_req)
          next_state = mbsp_pkg::ST_STOP;
        else if (expired)
          next_state = mbsp_pkg::ST_RUN;
      mbsp_pkg::ST_RUN:
        if (!op_enable_req)
          next_state = mbsp_pkg::ST_STOP;
      mbsp_pkg::ST_STOP:
        if (motor_standstill)
        begin
          next_state = mbsp_pkg::ST_HOLD;
          load = 1'b1;
          load_val = t_stop;
        end
      mbsp_pkg::ST_HOLD:
        if (expired)
        begin
          next_state = mbsp_pkg::ST_ENGAGE;
          load = 1'b1;
          load_val = t_engage;
        end
      mbsp_pkg::ST_ENGAGE:
        if (expired)
          next_state = mbsp_pkg::ST_OFF;
      default:
        next_state = mbsp_pkg::ST_OFF;
    endcase
    next_current_on = (next_state != mbsp_pkg::ST_OFF);
    next_stop_req = (next_state == mbsp_pkg::ST_STOP);
    next_motion_enable = (next_state == mbsp_pkg::ST_RUN);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= mbsp_pkg::ST_OFF;
      motor_current_on <= 1'b0;
      motor_stop_req <= 1'b0;
      motion_enable <= 1'b0;
    end
    else
    begin
      state <= next_state;
      motor_current_on <= next_current_on;
      motor_stop_req <= next_stop_req;
      motion_enable <= next_motion_enable;
    end
  end

  // Brake selection and PWM drive
  assign auto_mode = drive_submode_select[mbsp_pkg::AUTO_BIT];
  assign seq_release = (state == mbsp_pkg::ST_SETTLE) || (state == mbsp_pkg::ST_RUN) ||
                       (state == mbsp_pkg::ST_STOP) || (state == mbsp_pkg::ST_HOLD);
  assign brake_release = auto_mode ? seq_release :
                         digital_output_word[mbsp_pkg::BRAKE_BIT];

  assign pwm_bus.en = brake_release;
  assign pwm_bus.freq = pwm_freq;
  assign pwm_bus.duty = pwm_duty;
  assign brake_out = pwm_bus.wave;

  mbsp_pwm u_pwm (
    .pclk(pclk),
    .presetn(presetn),
    .pwm(pwm_bus.gen)
  );

endmodule

// file: tb/mbsp_brake_model.sv
`timescale 1ns/10ps
module mbsp_brake_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic brake_out,
  input wire logic motor_stop_req,
  output logic motor_standstill,
  output logic brake_released
);
  logic [1:0] coast;
  // Motor coasts a few cycles, so standstill never answers a stop at once
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      coast <= 2'h0;
      brake_released <= 1'b0;
    end
    else
    begin
      coast <= motor_stop_req ? coast + 2'(coast != 2'h3) : 2'h0;
      brake_released <= brake_out;
    end
  assign motor_standstill = coast == 2'h3;
endmodule

// file: tb/mbsp_top_properties.sv
`timescale 1ns/10ps
module mbsp_props #(
  parameter int unsigned MS_CYCLES = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic op_enable_req,
  input wire logic motor_standstill,
  input wire logic motor_current_on,
  input wire logic motor_stop_req,
  input wire logic motion_enable,
  input wire logic brake_out
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic acc;
  logic auto_q;
  logic next_auto_q;
  assign acc = psel && penable;
  // Shadow of the mode bit, so brake checks apply to automatic mode only
  always_comb
    next_auto_q = (acc && pwrite && paddr == 12'h000) ? pwdata[2] : auto_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      auto_q <= 1'b1;
    else
      auto_q <= next_auto_q;
  sequence s_wr(logic [11:0] a);
    acc && pwrite && paddr == a;
  endsequence
  sequence s_go;
    $rose(motor_current_on) && auto_q;
  endsequence
  property p_freq_rej;
    s_wr(12'h018) ##0 (pwdata[15:0] > 16'h07d0 || pwdata[15:0] == 16'h0000) |-> pslverr;
  endproperty
  a_freq_rej: assert property (p_freq_rej) else $error("bad freq taken");
  property p_duty_rej;
    s_wr(12'h01c) ##0 (pwdata[7:0] == 8'h00 || pwdata[7:0] > 8'h64) |-> pslverr;
  endproperty
  a_duty_rej: assert property (p_duty_rej) else $error("bad duty taken");
  property p_auto_closed;
    auto_q && $past(auto_q, 4) && !motor_current_on |-> !brake_out;
  endproperty
  a_auto_closed: assert property (p_auto_closed) else $error("brake open");
  property p_cur_first;
    s_go |-> !brake_out [*8];
  endproperty
  a_cur_first: assert property (p_cur_first) else $error("early release");
  property p_motion_cur;
    motion_enable |-> motor_current_on && !motor_stop_req;
  endproperty
  a_motion_cur: assert property (p_motion_cur) else $error("motion no current");
  property p_engage;
    $fell(motor_current_on) && auto_q |-> !brake_out && $past(brake_out, 4) == 1'b0;
  endproperty
  a_engage: assert property (p_engage) else $error("current off first");
  property p_req_drop;
    $fell(op_enable_req) ##0 motion_enable |-> ##[1:2] motor_stop_req && !motion_enable;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("no stop");
  property p_stop_hold;
    $rose(motor_stop_req) && auto_q |-> motor_current_on [*3];
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("current dropped");
endmodule
bind mbsp_top mbsp_props #(.MS_CYCLES(MS_CYCLES)) u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_enable_req(op_enable_req),
  .motor_standstill(motor_standstill), .motor_current_on(motor_current_on),
  .motor_stop_req(motor_stop_req), .motion_enable(motion_enable), .brake_out(brake_out));

// file: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, op_enable_req, motor_standstill, brake_released;
  logic motor_current_on, motor_stop_req, motion_enable, brake_out;
  int num_errors = 0;
  int total_checks = 0;
  mbsp_top #(.MS_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .op_enable_req(op_enable_req),
    .motor_standstill(motor_standstill), .motor_current_on(motor_current_on),
    .motor_stop_req(motor_stop_req), .motion_enable(motion_enable), .brake_out(brake_out));
  mbsp_brake_model u_brake (.pclk(pclk), .presetn(presetn), .brake_out(brake_out),
    .motor_stop_req(motor_stop_req), .motor_standstill(motor_standstill),
    .brake_released(brake_released));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits for the slave as long as it takes; only the watchdog ends a hung transfer
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk("pslverr", 32'(e), 32'(ee));
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk("pslverr", 32'(e), 32'(ee));
    chk("prdata", r, x);
  endtask
  // Samples on the falling edge so registered outputs have settled
  task automatic wt(ref logic s, input logic v, output int n);
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (s !== v && n < 30000);
    if (s !== v)
    begin
      num_errors++;
      summarize();
    end
  endtask
  task automatic req(input logic v);
    @(posedge pclk);
    op_enable_req <= v;
  endtask
  task automatic t_regs;
    rd(12'h000, 32'h0000_0004, 1'b0);
    rd(12'h020, 32'h0000_0000, 1'b0);
    rd(12'h018, 32'h0000_03e8, 1'b0);
    wr(12'h018, 32'h0000_07d1, 1'b1);
    wr(12'h018, 32'h0000_0000, 1'b1);
    wr(12'h01c, 32'h0000_0000, 1'b1);
    wr(12'h01c, 32'h0000_0065, 1'b1);
    rd(12'h018, 32'h0000_03e8, 1'b0);
    rd(12'h01c, 32'h0000_0064, 1'b0);
    wr(12'h024, 32'h0000_0001, 1'b1);
    rd(12'h024, 32'h0000_0000, 1'b1);
    $display("test regs done");
  endtask
  task automatic t_auto;
    int n;
    int m;
    for (int i = 0; i < 4; i++)
      wr(12'h008 + 12'(4 * i), 32'h0000_0002, 1'b0);
    req(1'b1);
    wt(motor_current_on, 1'b1, n);
    chk("brake_early", 32'(brake_out), 32'h0000_0000);
    wt(brake_out, 1'b1, n);
    chk("release_wait", 32'(n >= 8), 32'h0000_0001);
    chk("motion_early", 32'(motion_enable), 32'h0000_0000);
    wt(motion_enable, 1'b1, m);
    chk("settle_wait", 32'(m >= 8), 32'h0000_0001);
    m = 0;
    repeat (40)
    begin
      @(negedge pclk);
      m += int'(brake_out === 1'b1);
    end
    chk("duty_full", 32'(m), 32'h0000_0028);
    chk("released", 32'(brake_released), 32'h0000_0001);
    rd(12'h020, 32'h0000_0072, 1'b0);
    req(1'b0);
    wt(motor_stop_req, 1'b1, n);
    chk("stop_motion", 32'(motion_enable), 32'h0000_0000);
    wt(brake_out, 1'b0, n);
    chk("hold_wait", 32'(n >= 8), 32'h0000_0001);
    chk("current_kept", 32'(motor_current_on), 32'h0000_0001);
    wt(motor_current_on, 1'b0, n);
    chk("engage_wait", 32'(n >= 8), 32'h0000_0001);
    $display("test auto done");
  endtask
  task automatic t_pwm;
    int n;
    int m;
    wr(12'h018, 32'h0000_07d0, 1'b0);
    wr(12'h01c, 32'h0000_0019, 1'b0);
    req(1'b1);
    wt(brake_out, 1'b1, n);
    m = 0;
    // One full period of 20000 cycles at the highest frequency
    repeat (20000)
    begin
      @(negedge pclk);
      m += int'(brake_out === 1'b1);
    end
    chk("pwm_high", 32'(m), 32'h0000_1388);
    req(1'b0);
    wt(motor_current_on, 1'b0, n);
    chk("pwm_stopped", 32'(brake_out), 32'h0000_0000);
    $display("test pwm done");
  endtask
  task automatic t_manual;
    int n;
    wr(12'h01c, 32'h0000_0064, 1'b0);
    wr(12'h000, 32'h0000_0000, 1'b0);
    wr(12'h004, 32'h0000_0001, 1'b0);
    wt(brake_out, 1'b1, n);
    chk("manual_on", 32'(n < 8), 32'h0000_0001);
    wr(12'h004, 32'h0000_0000, 1'b0);
    wt(brake_out, 1'b0, n);
    chk("manual_off", 32'(n < 8), 32'h0000_0001);
    wr(12'h004, 32'h0000_0001, 1'b0);
    wr(12'h000, 32'h0000_0004, 1'b0);
    repeat (6) @(negedge pclk);
    chk("auto_closed", 32'(brake_out), 32'h0000_0000);
    $display("test manual done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, op_enable_req} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_auto();
    t_pwm();
    t_manual();
    summarize();
  end
  initial
  begin
    repeat (40000) @(posedge pclk);
    num_errors++;
    summarize();
  end
endmodule
